// ===== design/adcseq_params.svh
// constants for the converter sequencer: timing counts, channel map, reset values
`ifndef ADCSEQ_PARAMS_SVH
`define ADCSEQ_PARAMS_SVH

`define ADCSEQ_RES_BITS      10
`define ADCSEQ_CH_BITS       3
`define ADCSEQ_NUM_REGS      4
// synchronisation delay, states (slow / fast)
`define ADCSEQ_DLY_SLOW      5'h0a
`define ADCSEQ_DLY_FAST      5'h06
// sampling interval, states
`define ADCSEQ_SPL_SLOW      9'h03f
`define ADCSEQ_SPL_FAST      9'h01f
// full slot of a scan conversion, states
`define ADCSEQ_SLOT_SLOW     9'h100
`define ADCSEQ_SLOT_FAST     9'h080
`define ADCSEQ_ONE9          9'h001
`define ADCSEQ_ONE5          5'h01
`define ADCSEQ_ZERO9         9'h000
`define ADCSEQ_ZERO5         5'h00
`define ADCSEQ_ZERO_RES      10'h000
`define ADCSEQ_BIT_TOP       4'h9
`define ADCSEQ_ONE4          4'h1
`define ADCSEQ_ZERO4         4'h0
`define ADCSEQ_ZERO_CH       3'h0
`define ADCSEQ_GRP_BIT       2
`endif

// ===== design/adcseq_pkg.sv
// types shared by the converter sequencer modules
package adcseq_pkg;
  typedef enum logic [2:0] {
    ADCSEQ_IDLE   = 3'b000,
    ADCSEQ_SYNC   = 3'b001,
    ADCSEQ_SAMPLE = 3'b010,
    ADCSEQ_CONV   = 3'b011,
    ADCSEQ_DONE   = 3'b100
  } adcseq_state_e;
  typedef logic [9:0] adcseq_res_t;
endpackage : adcseq_pkg

// ===== design/adcseq_sar_if.sv
// link between sequencer and successive-approximation register
`timescale 1ns/1ps
interface adcseq_sar_if;
  logic        start;
  logic        abort;
  logic        cmpHigh;
  logic [9:0]  trial;
  logic        busy;
  logic        done;
  logic [9:0]  result;
  modport seq (output start, output abort, input busy, input done, input result, input trial);
  modport sar (input start, input abort, input cmpHigh, output trial, output busy, output done, output result);
endinterface : adcseq_sar_if

// ===== design/adcseq_sar.sv
// ten-bit successive-approximation register, one bit decided per step
`timescale 1ns/1ps
`include "adcseq_params.svh"
module adcseq_sar
  import adcseq_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // step pacing from sequencer
  input  wire logic stepEn,
  // sequencer link
  adcseq_sar_if.sar sarIf
);
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [3:0]  bitIdx;
    adcseq_res_t trial;
    adcseq_res_t result;
  } adcseq_sar_s;

  adcseq_sar_s st_r;
  adcseq_sar_s st_nxt;

  // ==========================================================
  // approximation steps
  // one bit per step, top bit first, so ten steps give ten bits
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (sarIf.abort) begin
      st_nxt.busy = 1'b0;
    end else if (sarIf.start) begin
      st_nxt.busy   = 1'b1;
      st_nxt.bitIdx = `ADCSEQ_BIT_TOP;
      st_nxt.trial  = `ADCSEQ_ZERO_RES;
      st_nxt.trial[`ADCSEQ_BIT_TOP] = 1'b1;
    end else if (st_r.busy && stepEn) begin
      // keep the trial bit only if input is at or above the trial level [R1]
      st_nxt.trial[st_r.bitIdx] = sarIf.cmpHigh;
      if (st_r.bitIdx == `ADCSEQ_ZERO4) begin
        st_nxt.busy   = 1'b0;
        st_nxt.done   = 1'b1;
        st_nxt.result = {st_r.trial[9:1], sarIf.cmpHigh}; // [R1]
      end else begin
        st_nxt.bitIdx = st_r.bitIdx - `ADCSEQ_ONE4;
        st_nxt.trial[st_r.bitIdx - `ADCSEQ_ONE4] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sarIf.busy   = st_r.busy;
  assign sarIf.done   = st_r.done;
  assign sarIf.result = st_r.result;
  assign sarIf.trial  = st_r.trial;

  a_sar_ten_bits: assert property (@(posedge clock) disable iff (!rst_b)
    sarIf.done |-> $past(st_r.bitIdx) == `ADCSEQ_ZERO4) // [R1]
    else $error("result produced before all ten bits decided");
endmodule : adcseq_sar

// ===== design/adcseq_top.sv
// converter sequencer: single and scan modes, start bit, end flag, trigger, timing
// How it works
// [R1] results come from a ten-bit successive-approximation register
// [R2] single mode starts on start bit or trigger; bit clears when conversion ends
// [R3] completion sets end flag; interrupt raised same cycle when enabled
// [R4] end flag clears only by status read while set, then writing zero
// [R5] halt before mode/channel changes; start may be set with new selection
// [R6] single result goes to the selected channel's register, then idle
// [R7] channels 0/4 to register a, up to channels 3/7 to register d
// [R8] scan starts on channel 0 or channel 4 by group select
// [R9] scan converts channels back to back, cycling until start bit clears
// [R10] after last scan channel: set flag, request interrupt, restart group
// [R11] scan restart after a stop resumes from the group's first channel
// [R12] synchronisation delay before sampling, 10-17 slow, 6-9 fast states
// [R13] sampling lasts 63 slow or 31 fast states
// [R14] first conversion totals 259-266 slow or 131-134 fast states
// [R15] later scan conversions take exactly 256 slow or 128 fast states
// [R16] with trigger enabled, a falling trigger edge sets start bit
// [R17] triggered conversion behaves exactly like a software start
// [R18] trigger ignored while disabled; edges found after synchronisation
// [R19] clearing start bit aborts without result store or end flag
`timescale 1ns/1ps
`include "adcseq_params.svh"
module adcseq_top
  import adcseq_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // control/status register write side and status read strobe
  input  wire logic        ctrlWrite,
  input  wire logic        wrStartBit,
  input  wire logic        wrEndFlag,
  input  wire logic        wrIrqEnable,
  input  wire logic        wrScanMode,
  input  wire logic        wrTimeSelect,
  input  wire logic [2:0]  wrChannel,
  input  wire logic        statusRead,
  // trigger configuration and pin
  input  wire logic        extTriggerEnable,
  input  wire logic        extTriggerInput,
  // analog comparator
  input  wire logic        cmpHigh,
  // status outputs
  output logic             conversionStartBit,
  output logic             conversionEndFlag,
  output logic             endIrqEnable,
  output logic             scanMode,
  output logic             conversionTimeSelect,
  output logic [2:0]       channelSelect,
  output logic             endOfConversionIrq,
  output logic [9:0]       resultRegA,
  output logic [9:0]       resultRegB,
  output logic [9:0]       resultRegC,
  output logic [9:0]       resultRegD,
  output logic [2:0]       activeChannel
);
  typedef struct packed {
    adcseq_state_e state;
    logic          start;
    logic          endFlag;
    logic          flagSeen;
    logic          irqEn;
    logic          scan;
    logic          conversion_time_select;
    logic [2:0]    chSel;
    logic [2:0]    curCh;
    logic          irq;
    logic          firstConv;
    logic [4:0]    dlyCnt;
    logic [8:0]    slotCnt;
    logic [1:0]    trgSync;
    logic          trgLast;
    logic [3:0][9:0] result;
  } adcseq_top_s;

  adcseq_top_s st_r;
  adcseq_top_s st_nxt;

  adcseq_sar_if sarIf ();
  logic         stepEn;
  logic         trigFall;
  logic         startReq;
  logic [4:0]   dlyLen;
  logic [8:0]   splLen;
  logic [8:0]   slotLen;
  logic [2:0]   grpFirst;
  logic [2:0]   grpLast;

  // ==========================================================
  // approximation core
  adcseq_sar u_sar (
    .clock (clock),
    .rst_b (rst_b),
    .stepEn(stepEn),
    .sarIf (sarIf.sar)
  );
  assign sarIf.cmpHigh = cmpHigh;

  // ==========================================================
  // derived timing and channel range
  // slow option stretches every phase, so the slot doubles too
  assign dlyLen   = st_r.conversion_time_select ? `ADCSEQ_DLY_FAST : `ADCSEQ_DLY_SLOW;   // [R12]
  assign splLen   = st_r.conversion_time_select ? `ADCSEQ_SPL_FAST : `ADCSEQ_SPL_SLOW;   // [R13]
  assign slotLen  = st_r.conversion_time_select ? `ADCSEQ_SLOT_FAST : `ADCSEQ_SLOT_SLOW; // [R15]
  assign grpFirst = {st_r.chSel[`ADCSEQ_GRP_BIT], 2'b00};             // [R8]
  assign grpLast  = st_r.scan ? st_r.chSel : grpFirst;
  // one approximation step every 16 (slow) or 8 (fast) states keeps the sar inside the slot
  assign stepEn   = st_r.conversion_time_select ? (st_r.slotCnt[2:0] == 3'h7) : (st_r.slotCnt[3:0] == 4'hf);
  // edge taken from the second synchroniser stage only [R18]
  assign trigFall = st_r.trgLast & ~st_r.trgSync[1];
  assign startReq = extTriggerEnable & trigFall;                     // [R16]

  // ==========================================================
  // next state
  always_comb begin
    st_nxt            = st_r;
    st_nxt.irq        = 1'b0;
    st_nxt.trgSync    = {st_r.trgSync[0], extTriggerInput};
    st_nxt.trgLast    = st_r.trgSync[1];
    sarIf.start       = 1'b0;
    sarIf.abort       = 1'b0;
    // register write; new selection may arrive with the start bit [R5]
    if (ctrlWrite) begin
      st_nxt.irqEn = wrIrqEnable;
      st_nxt.scan  = wrScanMode;
      st_nxt.conversion_time_select   = wrTimeSelect;
      st_nxt.chSel = wrChannel;
      st_nxt.start = wrStartBit;
      // zero clears the flag only after it was read as one [R4]
      if (!wrEndFlag && st_r.flagSeen) begin
        st_nxt.endFlag = 1'b0;
      end
      st_nxt.flagSeen = 1'b0;
    end
    if (statusRead && st_r.endFlag) begin
      st_nxt.flagSeen = 1'b1; // [R4]
    end
    if (startReq) begin
      st_nxt.start = 1'b1; // [R16] [R17]
    end
    unique case (st_r.state)
      ADCSEQ_IDLE: begin
        if (st_nxt.start) begin
          st_nxt.state     = ADCSEQ_SYNC;
          // a fresh scan start always begins at the group head [R8] [R11]
          st_nxt.curCh     = ctrlWrite ? {wrChannel[`ADCSEQ_GRP_BIT], 2'b00} : grpFirst;
          if (!(ctrlWrite ? wrScanMode : st_r.scan)) begin
            st_nxt.curCh = ctrlWrite ? wrChannel : st_r.chSel; // [R6]
          end
          st_nxt.firstConv = 1'b1;
          st_nxt.dlyCnt    = `ADCSEQ_ONE5;
        end
      end
      ADCSEQ_SYNC: begin
        st_nxt.dlyCnt = st_r.dlyCnt + `ADCSEQ_ONE5;
        if (st_r.dlyCnt == dlyLen) begin // [R12]
          st_nxt.state   = ADCSEQ_SAMPLE;
          st_nxt.slotCnt = `ADCSEQ_ONE9;
        end
      end
      ADCSEQ_SAMPLE: begin
        st_nxt.slotCnt = st_r.slotCnt + `ADCSEQ_ONE9;
        if (st_r.slotCnt == splLen) begin // [R13]
          st_nxt.state = ADCSEQ_CONV;
          sarIf.start  = 1'b1;
        end
      end
      ADCSEQ_CONV: begin
        st_nxt.slotCnt = st_r.slotCnt + `ADCSEQ_ONE9;
        // whole slot counted from sampling start: first conversion = delay + slot [R14] [R15]
        // the done state is the slot's last state, so counting stops one short of the slot
        if (st_r.slotCnt == (slotLen - `ADCSEQ_ONE9)) begin
          st_nxt.state = ADCSEQ_DONE;
        end
      end
      ADCSEQ_DONE: begin
        st_nxt.result[st_r.curCh[1:0]] = sarIf.result; // [R6] [R7] [R9]
        if (!st_r.scan) begin
          st_nxt.start   = 1'b0;                      // [R2]
          st_nxt.endFlag = 1'b1;                      // [R3]
          st_nxt.irq     = st_r.irqEn;                // [R3]
          st_nxt.state   = ADCSEQ_IDLE;
        end else begin
          // next channel straight away, no resync [R9] [R15]
          st_nxt.state     = ADCSEQ_SAMPLE;
          st_nxt.slotCnt   = `ADCSEQ_ONE9;
          st_nxt.firstConv = 1'b0;
          if (st_r.curCh == grpLast) begin
            st_nxt.curCh   = grpFirst;                // [R10]
            st_nxt.endFlag = 1'b1;                    // [R10]
            st_nxt.irq     = st_r.irqEn;              // [R10]
          end else begin
            st_nxt.curCh = st_r.curCh + 3'h1;         // [R9]
          end
        end
      end
      default: begin
        st_nxt.state = ADCSEQ_IDLE;
      end
    endcase
    // software stop discards work in flight; set beats clear for start via trigger [R19]
    if (!st_nxt.start && st_r.state != ADCSEQ_IDLE && st_r.state != ADCSEQ_DONE) begin
      st_nxt.state = ADCSEQ_IDLE;
      sarIf.abort  = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r         <= '0;
      st_r.trgSync <= 2'b11;
      st_r.trgLast <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign conversionStartBit   = st_r.start;
  assign conversionEndFlag    = st_r.endFlag;
  assign endIrqEnable         = st_r.irqEn;
  assign scanMode             = st_r.scan;
  assign conversionTimeSelect = st_r.conversion_time_select;
  assign channelSelect        = st_r.chSel;
  assign endOfConversionIrq   = st_r.irq;
  assign resultRegA           = st_r.result[0];
  assign resultRegB           = st_r.result[1];
  assign resultRegC           = st_r.result[2];
  assign resultRegD           = st_r.result[3];
  assign activeChannel        = st_r.curCh;

  // ==========================================================
  // checks
  // interrupt only ever accompanies the flag it reports
  a_irq_with_flag: assert property (@(posedge clock) disable iff (!rst_b)
    endOfConversionIrq |-> conversionEndFlag && endIrqEnable) // [R3]
    else $error("interrupt without end flag and enable");
  a_single_clears_start: assert property (@(posedge clock) disable iff (!rst_b)
    (st_r.state == ADCSEQ_DONE && !st_r.scan) |=> !conversionStartBit && conversionEndFlag) // [R2]
    else $error("single conversion end did not clear start");
  a_flag_clear_order: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(conversionEndFlag) |-> $past(st_r.flagSeen) && $past(ctrlWrite)) // [R4]
    else $error("end flag cleared without read first");
  a_scan_group_head: assert property (@(posedge clock) disable iff (!rst_b)
    (st_r.state == ADCSEQ_IDLE && st_nxt.state == ADCSEQ_SYNC && st_nxt.scan)
    |=> activeChannel[1:0] == 2'b00) // [R8]
    else $error("scan did not begin at group head");
  // slow delay: at least eight more states spent in sync after it begins
  a_sync_delay_len: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(st_r.state == ADCSEQ_SYNC) && !st_r.conversion_time_select |-> (st_r.state == ADCSEQ_SYNC) [*8] ##1
    (st_r.state == ADCSEQ_SYNC)) // [R12]
    else $error("synchronisation delay too short");
  // sampling counts 1..31, so conversion is seen 31 states after the first sample state
  a_sample_len: assert property (@(posedge clock) disable iff (!rst_b)
    (st_r.state == ADCSEQ_SAMPLE && st_r.slotCnt == `ADCSEQ_ONE9 && st_r.conversion_time_select && st_r.start)
    |-> ##31 ((st_r.state == ADCSEQ_CONV) || !st_r.start)) // [R13]
    else $error("fast sampling not 31 states");
  // done to done is one whole scan slot
  a_scan_slot_len: assert property (@(posedge clock) disable iff (!rst_b)
    (st_r.state == ADCSEQ_DONE && st_r.scan && st_r.conversion_time_select && st_nxt.start)
    |-> ##128 ((st_r.state == ADCSEQ_DONE) || !st_r.start)) // [R15]
    else $error("fast scan slot not 128 states");
  a_trig_ignored: assert property (@(posedge clock) disable iff (!rst_b)
    (!extTriggerEnable && !ctrlWrite && !conversionStartBit) |=> !conversionStartBit) // [R18]
    else $error("start set while trigger disabled");
  // an abort must not raise the flag and must leave every result untouched
  a_abort_no_store: assert property (@(posedge clock) disable iff (!rst_b)
    (sarIf.abort) |=> !$rose(conversionEndFlag) && $stable({resultRegA, resultRegB, resultRegC, resultRegD})) // [R19]
    else $error("abort set the end flag or stored a result");

  // ==========================================================
  // further timing and sequencing checks
  // the interrupt is a single-cycle pulse
  a_irq_one_cycle: assert property (@(posedge clock) disable iff (!rst_b)
    endOfConversionIrq |=> !endOfConversionIrq) // [R3]
    else $error("interrupt pulse longer than one cycle");
  // slow first conversion: done state 265 states after sync begins, 266 in all
  a_first_conv_slow: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(st_r.state == ADCSEQ_SYNC) && !st_r.conversion_time_select |-> ##265 ((st_r.state == ADCSEQ_DONE) || !st_r.start)) // [R14]
    else $error("slow first conversion outside its time");
  // fast first conversion: 134 states in all
  a_first_conv_fast: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(st_r.state == ADCSEQ_SYNC) && st_r.conversion_time_select |-> ##133 ((st_r.state == ADCSEQ_DONE) || !st_r.start)) // [R14]
    else $error("fast first conversion outside its time");
  // results move only in the done state
  a_result_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (st_r.state != ADCSEQ_DONE) |=> $stable({resultRegA, resultRegB, resultRegC, resultRegD})) // [R6]
    else $error("result changed outside a completed conversion");
  // last scan channel done: flag up and back to the group head
  a_scan_wraps: assert property (@(posedge clock) disable iff (!rst_b)
    (st_r.state == ADCSEQ_DONE && st_r.scan && st_r.curCh == st_r.chSel && st_nxt.start)
    |=> activeChannel[1:0] == 2'b00 && conversionEndFlag) // [R10]
    else $error("scan did not wrap to group head with flag");
  // enabled trigger edge sets start; a single-mode done state clears it in the same cycle
  a_trig_starts: assert property (@(posedge clock) disable iff (!rst_b)
    (extTriggerEnable && trigFall && st_r.state != ADCSEQ_DONE) |=> conversionStartBit) // [R16]
    else $error("trigger edge did not set start");
endmodule : adcseq_top

// ===== tb/adcseq_analog_model.sv
// behavioural analog front end: one fixed level per input channel
`timescale 1ns/1ps
module adcseq_analog_model #(
  parameter logic [7:0] LEVELS = 8'h52
) (
  // channel under conversion
  input  wire logic [2:0] activeChannel,
  // comparator answer
  output logic            cmpHigh
);
  // =========================================
  // comparator
  // trial level is not visible at the pins, so each channel sits at full scale or zero
  assign cmpHigh = LEVELS[activeChannel];
endmodule : adcseq_analog_model

// ===== tb/adcseq_top_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adcseq_top_tb;
  import adcseq_pkg::*;
  logic clock, rst_b, ctrlWrite, wrStartBit, wrEndFlag, wrIrqEnable, wrScanMode, wrTimeSelect, statusRead;
  logic [2:0] wrChannel, channelSelect, activeChannel;
  logic extTriggerEnable, extTriggerInput, cmpHigh, conversionStartBit, conversionEndFlag, endIrqEnable;
  logic scanMode, conversionTimeSelect, endOfConversionIrq;
  logic [9:0] resultRegA, resultRegB, resultRegC, resultRegD;
  int miscompares, n_checks, cyc, irqCount, n;

  // =========================================
  // design and analog partner
  adcseq_top dut (.clock(clock), .rst_b(rst_b), .ctrlWrite(ctrlWrite), .wrStartBit(wrStartBit),
    .wrEndFlag(wrEndFlag), .wrIrqEnable(wrIrqEnable), .wrScanMode(wrScanMode), .wrTimeSelect(wrTimeSelect),
    .wrChannel(wrChannel), .statusRead(statusRead), .extTriggerEnable(extTriggerEnable),
    .extTriggerInput(extTriggerInput), .cmpHigh(cmpHigh), .conversionStartBit(conversionStartBit),
    .conversionEndFlag(conversionEndFlag), .endIrqEnable(endIrqEnable), .scanMode(scanMode),
    .conversionTimeSelect(conversionTimeSelect), .channelSelect(channelSelect),
    .endOfConversionIrq(endOfConversionIrq), .resultRegA(resultRegA), .resultRegB(resultRegB),
    .resultRegC(resultRegC), .resultRegD(resultRegD), .activeChannel(activeChannel));
  adcseq_analog_model #(.LEVELS(8'h52)) model (.activeChannel(activeChannel), .cmpHigh(cmpHigh));

  // =========================================
  // clock, watchdog, interrupt pulse counter
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (endOfConversionIrq === 1'b1) irqCount <= irqCount + 1;
    if (cyc == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  // =========================================
  // access tasks
  task automatic tick();
    @(posedge clock);
    #2;
  endtask : tick
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // one control/status write; all fields taken together
  task automatic wr(input logic st, input logic fl, input logic ie, input logic sc, input logic ts,
                    input logic [2:0] ch);
    ctrlWrite = 1'b1;
    wrStartBit = st;
    wrEndFlag = fl;
    wrIrqEnable = ie;
    wrScanMode = sc;
    wrTimeSelect = ts;
    wrChannel = ch;
    tick();
    ctrlWrite = 1'b0;
  endtask : wr
  task automatic rd();
    statusRead = 1'b1;
    tick();
    statusRead = 1'b0;
  endtask : rd
  // cycles until the start bit drops, bounded
  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (conversionStartBit === 1'b1 && cnt < 400) begin
      tick();
      cnt++;
    end
  endtask : wait_idle
  task automatic wait_chan(input logic [2:0] target, output int cnt);
    cnt = 0;
    while (activeChannel !== target && cnt < 400) begin
      tick();
      cnt++;
    end
  endtask : wait_chan
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // =========================================
  // test sequence
  initial begin
    {ctrlWrite, wrStartBit, wrEndFlag, wrIrqEnable, wrScanMode, wrTimeSelect, statusRead} = 7'h00;
    wrChannel = 3'h0;
    extTriggerEnable = 1'b0;
    extTriggerInput = 1'b1;
    rst_b = 1'b0;
    {miscompares, n_checks, cyc, irqCount} = '0;
    repeat (8) tick();
    rst_b = 1'b1;
    check({conversionStartBit, conversionEndFlag, endIrqEnable, scanMode, conversionTimeSelect}, 16'h0000);
    check(resultRegA | resultRegB | resultRegC | resultRegD, 16'h0000);
    check({channelSelect, activeChannel, endOfConversionIrq}, 16'h0000);
    $display("test reset done");
    // single slow conversion on channel 1, interrupt enabled
    wr(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h1);
    check(conversionStartBit, 1'b1);
    wait_idle(n);
    check(n >= 259 && n <= 266, 1'b1);
    tick();
    check(resultRegB, 16'h03ff);
    check(conversionEndFlag, 1'b1);
    check(irqCount, 16'h0001);
    $display("test single done");
    // zero write without a prior read must be refused
    wr(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'h6);
    check(conversionEndFlag, 1'b1);
    check({endIrqEnable, scanMode, conversionTimeSelect, channelSelect}, 16'h002e);
    rd();
    wr(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'h6);
    check(conversionEndFlag, 1'b0);
    $display("test flag done");
    // trigger falls while disabled, then while enabled
    extTriggerInput = 1'b0;
    repeat (20) tick();
    check(conversionStartBit, 1'b0);
    extTriggerInput = 1'b1;
    extTriggerEnable = 1'b1;
    repeat (5) tick();
    extTriggerInput = 1'b0;
    repeat (3) tick();
    check(conversionStartBit, 1'b1);
    wait_idle(n);
    check(n >= 131 && n <= 134, 1'b1);
    tick();
    check(resultRegC, 16'h03ff);
    check(irqCount, 16'h0002);
    extTriggerEnable = 1'b0;
    extTriggerInput = 1'b1;
    rd();
    wr(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'h1);
    $display("test trigger done");
    tick();
    // abort a fast single conversion midway
    wr(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 3'h1);
    repeat (50) tick();
    wr(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 3'h1);
    repeat (200) tick();
    check({conversionStartBit, conversionEndFlag}, 16'h0000);
    check(irqCount, 16'h0002);
    $display("test abort done");
    // fast scan over channels 4 to 6, set together with the new mode
    wr(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h6);
    tick();
    check(activeChannel, 16'h0004);
    wait_chan(3'h5, n);
    wait_chan(3'h6, n);
    check(n, 16'h0080);
    wait_chan(3'h4, n);
    check(n, 16'h0080);
    tick();
    check(conversionEndFlag, 1'b1);
    check(irqCount, 16'h0003);
    check(resultRegA, 16'h03ff);
    check(resultRegB, 16'h0000);
    check(resultRegC, 16'h03ff);
    check(conversionStartBit, 1'b1);
    // stop during channel 5, restart from the group head
    wait_chan(3'h5, n);
    repeat (40) tick();
    wr(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h6);
    tick();
    wr(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h6);
    tick();
    check(activeChannel, 16'h0004);
    $display("test scan done");
    stop_test();
  end
endmodule : adcseq_top_tb
